//--- design/ianc_top.sv
// Purpose : interrupt enables, ack control and status for a serial bus interface
// Assumes : classic wishbone slave; link events arrive as single-cycle strobes
// Notes   : one level interrupt gathers the masked sticky flags
`default_nettype none

// Behaviour
// - nack enable at bit 4, reset 0, gates nack, arbitration and overrun requests.
// - nack request drops when its flags or the nack enable are cleared.
// - stop enable at bit 3, reset 0, gates the stop-detected request.
// - judgment bit 2 at 0 ignores received ack and keeps transferring.
// - judgment bit 2 at 1 with received ack 1 halts continuous transfer.
// - bit 1 captures received ack in transmit mode; writes never change it.
// - in receive mode bit 0 is driven on the data line during ack.
// - nack flag sets on missing ack in transmit, only with judgment on.
// - in master mode a stop after a finished frame sets the stop flag.
module ianc_top
  import ianc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // link events and modes
  input  wire logic        ack_slot_i,
  input  wire logic        ack_sample_i,
  input  wire logic        tx_mode_i,
  input  wire logic        master_mode_i,
  input  wire logic        clk_sync_fmt_i,
  input  wire logic        frame_done_i,
  input  wire logic        stop_seen_i,
  input  wire logic        arb_lost_set_i,
  input  wire logic        overrun_set_i,
  input  wire logic        resume_i,
  input  wire logic        sda_i,
  // data line, open drain
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // transfer control and requests
  output logic             halt_transfer_o,
  output logic             nack_irq_o,
  output logic             stop_irq_o,
  output logic             irq_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    ianc_wb_state_t st;
    logic [31:0]    rdata;
    logic           nack_ie;
    logic           stop_ie;
    logic           judge;
    logic           tx_ack;
    logic [3:0]     mask;
  } ianc_top_state_t;

  ianc_top_state_t               cur_r;
  ianc_top_state_t               cur_nxt;
  logic                          rx_ack;
  logic                          nack_event;
  logic [IANC_NFLAGS-1:0]        flag_set;
  logic [IANC_NFLAGS-1:0]        flag_clr;
  logic [IANC_NFLAGS-1:0]        flags;
  logic                          wr_fire;
  logic                          wr_ctrl;
  logic                          wr_status;
  logic                          wr_mask;
  logic [31:0]                   read_mux;
  logic [7:0]                    ctrl_view;

  // ************************************************************
  // ack unit
  // ************************************************************
  ianc_ack_unit i_ianc_ack_unit (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ack_slot_i   (ack_slot_i),
    .ack_sample_i (ack_sample_i),
    .tx_mode_i    (tx_mode_i),
    .sda_i        (sda_i),
    .resume_i     (resume_i),
    .judge_i      (cur_r.judge),
    .tx_ack_i     (cur_r.tx_ack),
    .rx_ack_o     (rx_ack),
    .nack_event_o (nack_event),
    .halt_o       (halt_transfer_o),
    .sda_o        (sda_o),
    .sda_oe_n_o   (sda_oe_n_o)
  );

  // ************************************************************
  // sticky flags
  // ************************************************************

  // flag set events
  always_comb begin
    flag_set                = '0;
    flag_set[IANC_FLG_NACK] = nack_event;
    flag_set[IANC_FLG_STOP] = stop_seen_i & master_mode_i & frame_done_i;
    flag_set[IANC_FLG_ARB]  = arb_lost_set_i;
    flag_set[IANC_FLG_OVR]  = overrun_set_i & clk_sync_fmt_i;
  end

  // write one to clear, at the acknowledged edge
  assign flag_clr = wr_status ? wb_dat_i[IANC_NFLAGS-1:0] : '0;

  ianc_flag_bank i_ianc_flag_bank (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (flag_set),
    .clr_i  (flag_clr),
    .flag_o (flags)
  );

  // ************************************************************
  // bus decode
  // ************************************************************

  // a write takes effect on the edge that sees ack
  assign wr_fire   = (cur_r.st == IANC_WB_ACK) & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
  assign wr_ctrl   = wr_fire & (wb_adr_i == IANC_OFS_CTRL);
  assign wr_status = wr_fire & (wb_adr_i == IANC_OFS_STATUS);
  assign wr_mask   = wr_fire & (wb_adr_i == IANC_OFS_MASK);

  // control byte as software sees it
  always_comb begin
    ctrl_view                   = '0;
    ctrl_view[IANC_BIT_NACK_IE] = cur_r.nack_ie;
    ctrl_view[IANC_BIT_STOP_IE] = cur_r.stop_ie;
    ctrl_view[IANC_BIT_JUDGE]   = cur_r.judge;
    ctrl_view[IANC_BIT_RX_ACK]  = rx_ack;
    ctrl_view[IANC_BIT_TX_ACK]  = cur_r.tx_ack;
  end

  // read data; unmapped offsets read zero
  always_comb begin
    read_mux = '0;
    unique case (wb_adr_i)
      IANC_OFS_CTRL: begin
        read_mux[7:0] = ctrl_view;
      end
      IANC_OFS_STATUS: begin
        read_mux[IANC_NFLAGS-1:0] = flags;
      end
      IANC_OFS_MASK: begin
        read_mux[IANC_NFLAGS-1:0] = cur_r.mask;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    cur_nxt = cur_r;
    unique case (cur_r.st)
      IANC_WB_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          cur_nxt.st    = IANC_WB_ACK;
          cur_nxt.rdata = read_mux;
        end
      end
      IANC_WB_ACK: begin
        cur_nxt.st = IANC_WB_IDLE;
      end
      default: begin
        cur_nxt.st = IANC_WB_IDLE;
      end
    endcase
    // control write; received ack bit is not writable
    if (wr_ctrl) begin
      cur_nxt.nack_ie = wb_dat_i[IANC_BIT_NACK_IE];
      cur_nxt.stop_ie = wb_dat_i[IANC_BIT_STOP_IE];
      cur_nxt.judge   = wb_dat_i[IANC_BIT_JUDGE];
      cur_nxt.tx_ack  = wb_dat_i[IANC_BIT_TX_ACK];
    end
    if (wr_mask) begin
      cur_nxt.mask = wb_dat_i[IANC_NFLAGS-1:0];
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r.st      <= IANC_WB_IDLE;
      cur_r.rdata   <= IANC_RST_RDATA;
      cur_r.nack_ie <= IANC_RST_NACK_IE;
      cur_r.stop_ie <= IANC_RST_STOP_IE;
      cur_r.judge   <= IANC_RST_JUDGE;
      cur_r.tx_ack  <= IANC_RST_TX_ACK;
      cur_r.mask    <= IANC_RST_MASK;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign wb_ack_o = (cur_r.st == IANC_WB_ACK);
  assign wb_dat_o = cur_r.rdata;

  // interrupt requests: level, flag and enable
  assign nack_irq_o = cur_r.nack_ie & (flags[IANC_FLG_NACK] | flags[IANC_FLG_ARB]
                      | (clk_sync_fmt_i & flags[IANC_FLG_OVR]));
  assign stop_irq_o = cur_r.stop_ie & flags[IANC_FLG_STOP];
  assign irq_o      = |(flags & cur_r.mask);  // masked sticky status

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_nack_enable_gate: assert property (!cur_r.nack_ie |-> !nack_irq_o)
    else $error("nack request raised while its enable is low");
  chk_nack_withdraw: assert property (flags == '0 |-> !nack_irq_o)
    else $error("nack request held with all flags clear");
  chk_stop_request: assert property (
    flag_set[IANC_FLG_STOP] && cur_r.stop_ie && !wr_ctrl |=> stop_irq_o)
    else $error("stop request missing after stop flag set");
  chk_stop_slave: assert property (
    stop_seen_i && !master_mode_i && !flags[IANC_FLG_STOP]
    && !(wr_status && wb_dat_i[IANC_FLG_STOP] == 1'b0) |=> !flags[IANC_FLG_STOP])
    else $error("stop flag set outside master mode");
  chk_nack_judge_off: assert property (
    ack_sample_i && !cur_r.judge && !flags[IANC_FLG_NACK] |=> !flags[IANC_FLG_NACK])
    else $error("nack flag set while judgment is off");
  chk_nack_set_wins: assert property (nack_event |=> flags[IANC_FLG_NACK])
    else $error("nack event lost");
  chk_ctrl_write: assert property (
    wr_ctrl |=> cur_r.nack_ie == $past(wb_dat_i[4]) && cur_r.stop_ie == $past(wb_dat_i[3]))
    else $error("control write not stored");
  chk_rx_ack_ro: assert property (
    wr_ctrl && !ack_sample_i |=> rx_ack == $past(rx_ack))
    else $error("received ack bit changed by a write");
  chk_irq_level: assert property (nack_irq_o && !wr_fire |=> nack_irq_o)
    else $error("nack request dropped without a clear");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held more than one cycle");

  cov_nack_irq: cover property (nack_event && cur_r.nack_ie ##1 nack_irq_o);
  cov_stop_irq: cover property (flag_set[IANC_FLG_STOP] && cur_r.stop_ie ##1 stop_irq_o);
  cov_clear_irq: cover property (irq_o ##1 wr_status ##1 !irq_o);

endmodule : ianc_top

`default_nettype wire

//--- common/ianc_pkg.sv
// Purpose : shared constants and types of the acknowledge / nack / stop interrupt control
// Assumes : classic wishbone slave, 32-bit data, byte addresses
// Notes   : control byte keeps the low five bits; upper bits read as zero
`default_nettype none

package ianc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] IANC_OFS_CTRL   = 4'h0;  // serial_bus_irq_ack_control
  localparam logic [3:0] IANC_OFS_STATUS = 4'h4;  // serial_bus_status_reg, write one to clear
  localparam logic [3:0] IANC_OFS_MASK   = 4'h8;  // interrupt mask, same layout as status

  // ************************************************************
  // control field positions and reset values
  // ************************************************************
  localparam int unsigned IANC_BIT_NACK_IE  = 4;  // nack_irq_enable
  localparam int unsigned IANC_BIT_STOP_IE  = 3;  // stop_detect_irq_enable
  localparam int unsigned IANC_BIT_JUDGE    = 2;  // ack_judgment_select
  localparam int unsigned IANC_BIT_RX_ACK   = 1;  // received_ack_bit, read only
  localparam int unsigned IANC_BIT_TX_ACK   = 0;  // transmitted_ack_bit
  localparam logic        IANC_RST_NACK_IE  = 1'b0;
  localparam logic        IANC_RST_STOP_IE  = 1'b0;
  localparam logic        IANC_RST_JUDGE    = 1'b0;
  localparam logic        IANC_RST_RX_ACK   = 1'b0;
  localparam logic        IANC_RST_TX_ACK   = 1'b0;

  // ************************************************************
  // status field positions and reset values
  // ************************************************************
  localparam int unsigned IANC_NFLAGS       = 4;
  localparam int unsigned IANC_FLG_NACK     = 0;  // nack_detected_flag
  localparam int unsigned IANC_FLG_STOP     = 1;  // stop detected flag
  localparam int unsigned IANC_FLG_ARB      = 2;  // arbitration_lost_flag
  localparam int unsigned IANC_FLG_OVR      = 3;  // overrun_flag
  localparam logic [3:0]  IANC_RST_FLAGS    = 4'h0;
  localparam logic [3:0]  IANC_RST_MASK     = 4'h0;
  localparam logic [31:0] IANC_RST_RDATA    = 32'h0000_0000;

  // ************************************************************
  // bus slave states
  // ************************************************************
  typedef enum logic [1:0] {
    IANC_WB_IDLE = 2'b01,
    IANC_WB_ACK  = 2'b10
  } ianc_wb_state_t;

endpackage : ianc_pkg

`default_nettype wire

//--- design/ianc_flag_bank.sv
// Purpose : bank of sticky status flags, set by events, cleared by writing one
// Assumes : set and clear are single-cycle strobes in the clk_i domain
// Notes   : a set arriving with its clear keeps the flag set
`default_nettype none

module ianc_flag_bank
  import ianc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // events and clears
  input  wire logic [IANC_NFLAGS-1:0] set_i,
  input  wire logic [IANC_NFLAGS-1:0] clr_i,
  // flags
  output logic      [IANC_NFLAGS-1:0] flag_o
);

  typedef struct packed {
    logic [IANC_NFLAGS-1:0] flag;
  } ianc_flag_state_t;

  ianc_flag_state_t                   cur_r;
  ianc_flag_state_t                   cur_nxt;
  logic             [IANC_NFLAGS-1:0] flag_nxt;

  // per flag: set wins over clear
  for (genvar g = 0; g < IANC_NFLAGS; g++) begin : g_flag
    assign flag_nxt[g] = set_i[g] | (cur_r.flag[g] & ~clr_i[g]);
  end

  // next state
  always_comb begin
    cur_nxt      = cur_r;
    cur_nxt.flag = flag_nxt;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r.flag <= IANC_RST_FLAGS;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign flag_o = cur_r.flag;

endmodule : ianc_flag_bank

`default_nettype wire

//--- design/ianc_ack_unit.sv
// Purpose : acknowledge capture, nack judgment and acknowledge drive
// Assumes : ack_sample_i pulses once at the ninth clock edge; ack_slot_i spans the ack clock
// Notes   : data line is open drain; the enable is active low
`default_nettype none

module ianc_ack_unit
  import ianc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // link side
  input  wire logic ack_slot_i,
  input  wire logic ack_sample_i,
  input  wire logic tx_mode_i,
  input  wire logic sda_i,
  input  wire logic resume_i,
  // control
  input  wire logic judge_i,
  input  wire logic tx_ack_i,
  // results
  output logic      rx_ack_o,
  output logic      nack_event_o,
  output logic      halt_o,
  output logic      sda_o,
  output logic      sda_oe_n_o
);

  typedef struct packed {
    logic rx_ack;
    logic halt;
    logic oe_n;
  } ianc_ack_state_t;

  ianc_ack_state_t cur_r;
  ianc_ack_state_t cur_nxt;
  logic            tx_sample;

  // received ack only judged in transmit mode
  assign tx_sample    = ack_sample_i & tx_mode_i;
  assign nack_event_o = tx_sample & sda_i & judge_i;

  // next state
  always_comb begin
    cur_nxt = cur_r;
    if (tx_sample) begin
      cur_nxt.rx_ack = sda_i;
    end
    if (nack_event_o) begin
      cur_nxt.halt = 1'b1;
    end else if (resume_i) begin
      cur_nxt.halt = 1'b0;
    end
    cur_nxt.oe_n = ~(ack_slot_i & ~tx_mode_i & ~tx_ack_i);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r.rx_ack <= IANC_RST_RX_ACK;
      cur_r.halt   <= 1'b0;
      cur_r.oe_n   <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign rx_ack_o   = cur_r.rx_ack;
  assign halt_o     = cur_r.halt;
  assign sda_o      = 1'b0;  // open drain: only ever pulls low
  assign sda_oe_n_o = cur_r.oe_n;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_halt_on_nack: assert property (tx_sample && sda_i && judge_i |=> halt_o)
    else $error("halt not raised on nack with judgment on");
  chk_no_halt_judge: assert property (ack_sample_i && !judge_i && !halt_o |=> !halt_o)
    else $error("halt raised while judgment off");
  chk_ack_drive: assert property (
    ack_slot_i && !tx_mode_i |=> sda_oe_n_o == $past(tx_ack_i))
    else $error("acknowledge drive does not follow the transmit ack bit");

endmodule : ianc_ack_unit

`default_nettype wire

//--- verif/ianc_link_model.sv
// Purpose : far side of the serial link, drives ack slots, events and modes
// Assumes : open-drain data line with a pull-up; device enable is active low
// Notes   : tasks are called by the bench; all changes land just after a rising edge
`default_nettype none

module ianc_link_model (
  // clock
  input  wire logic clk_i,
  // device data line drive
  input  wire logic sda_o,
  input  wire logic sda_oe_n_o,
  // link events and modes towards the device
  output logic      ack_slot_o,
  output logic      ack_sample_o,
  output logic      tx_mode_o,
  output logic      master_mode_o,
  output logic      clk_sync_fmt_o,
  output logic      frame_done_o,
  output logic      stop_seen_o,
  output logic      arb_lost_set_o,
  output logic      overrun_set_o,
  output logic      resume_o,
  output logic      sda_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive_r;  // model's own level, 1 means released

  // wired-and of both parties, pull-up when nobody pulls low
  assign sda_line_o = (!sda_oe_n_o && !sda_o) ? 1'b0 : drive_r;

  initial begin
    {ack_slot_o, ack_sample_o, tx_mode_o, master_mode_o, clk_sync_fmt_o} = '0;
    {frame_done_o, stop_seen_o, arb_lost_set_o, overrun_set_o, resume_o} = '0;
    drive_r = 1'b1;
  end

  // one acknowledge slot; level is returned only while the device transmits
  task automatic ack_bit(input logic tx, input logic level, output logic seen);
    @(posedge clk_i);
    tx_mode_o  <= tx;
    ack_slot_o <= 1'b1;
    drive_r    <= tx ? level : 1'b1;
    @(posedge clk_i);
    ack_sample_o <= 1'b1;
    @(posedge clk_i);
    seen = sda_line_o;
    ack_sample_o <= 1'b0;
    @(posedge clk_i);
    ack_slot_o <= 1'b0;
    drive_r    <= 1'b1;
  endtask : ack_bit

  // mode levels
  task automatic modes(input logic m, input logic d, input logic f);
    @(posedge clk_i);
    master_mode_o  <= m;
    frame_done_o   <= d;
    clk_sync_fmt_o <= f;
  endtask : modes

  // single-cycle event: 0 stop, 1 arbitration lost, 2 overrun, 3 resume
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: stop_seen_o <= 1'b1;
      1: arb_lost_set_o <= 1'b1;
      2: overrun_set_o <= 1'b1;
      default: resume_o <= 1'b1;
    endcase
    @(posedge clk_i);
    {stop_seen_o, arb_lost_set_o, overrun_set_o, resume_o} <= '0;
  endtask : pulse
endmodule : ianc_link_model

`default_nettype wire

//--- verif/ianc_top_tb_top.sv
// Purpose : self-checking bench of the ack / nack / stop interrupt control
// Assumes : one-cycle wishbone answer, link events one edge ahead of flags
// Notes   : every scenario is a task that judges its own results
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module ianc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ianc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, sda_o, oe_n, halt, nirq, sirq, irq;
  logic ac_slot, ac_smp, txm, mst, fmt, fdone, stp, arb, ovr, res, line;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic        seen;
  int          n_fail = 0;
  int          checks_done = 0;

  // ************************************************************
  // clock, reset and instances
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ianc_top i_ianc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .ack_slot_i(ac_slot), .ack_sample_i(ac_smp), .tx_mode_i(txm),
    .master_mode_i(mst), .clk_sync_fmt_i(fmt), .frame_done_i(fdone), .stop_seen_i(stp),
    .arb_lost_set_i(arb), .overrun_set_i(ovr), .resume_i(res), .sda_i(line),
    .sda_o(sda_o), .sda_oe_n_o(oe_n), .halt_transfer_o(halt), .nack_irq_o(nirq),
    .stop_irq_o(sirq), .irq_o(irq));

  ianc_link_model i_ianc_link_model (.clk_i(clk_i), .sda_o(sda_o), .sda_oe_n_o(oe_n),
    .ack_slot_o(ac_slot), .ack_sample_o(ac_smp), .tx_mode_o(txm), .master_mode_o(mst),
    .clk_sync_fmt_o(fmt), .frame_done_o(fdone), .stop_seen_o(stp), .arb_lost_set_o(arb),
    .overrun_set_o(ovr), .resume_o(res), .sda_line_o(line));

  // ************************************************************
  // bus tasks
  // ************************************************************
  // classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    #1;
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, q)
  endtask : rd

  task automatic lnk(input logic tx, input logic lv);
    i_ianc_link_model.ack_bit(tx, lv, seen);
    #1;
  endtask : lnk

  task automatic ev(input int k);
    i_ianc_link_model.pulse(k);
    #1;
  endtask : ev

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd(IANC_OFS_CTRL, 32'h0000_0000, "ctrl");
    rd(IANC_OFS_STATUS, 32'h0000_0000, "status");
    rd(IANC_OFS_MASK, 32'h0000_0000, "mask");
    rd(4'hC, 32'h0000_0000, "unmapped");
    `CHK("irq", 1'b0, irq)
    $display("test reset done");
  endtask : t_reset

  task automatic t_ctrl_rw;
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_001F);
    rd(IANC_OFS_CTRL, 32'h0000_001D, "ctrl_ro");
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0010);
    $display("test ctrl_rw done");
  endtask : t_ctrl_rw

  task automatic t_judge_off;
    lnk(1'b1, 1'b1);
    `CHK("halt", 1'b0, halt)
    rd(IANC_OFS_STATUS, 32'h0000_0000, "status");
    rd(IANC_OFS_CTRL, 32'h0000_0012, "rx_ack1");
    lnk(1'b1, 1'b0);
    rd(IANC_OFS_CTRL, 32'h0000_0010, "rx_ack0");
    $display("test judge_off done");
  endtask : t_judge_off

  task automatic t_judge_on;
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0014);
    wb(1'b1, IANC_OFS_MASK, 32'h0000_0001);
    lnk(1'b1, 1'b1);
    `CHK("halt", 1'b1, halt)
    `CHK("nack_irq", 1'b1, nirq)
    `CHK("irq", 1'b1, irq)
    rd(IANC_OFS_STATUS, 32'h0000_0001, "status");
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0004);
    `CHK("nack_irq_off", 1'b0, nirq)
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0014);
    `CHK("nack_irq_on", 1'b1, nirq)
    wb(1'b1, IANC_OFS_STATUS, 32'h0000_0001);
    `CHK("nack_irq_clr", 1'b0, nirq)
    `CHK("irq_clr", 1'b0, irq)
    ev(3);
    `CHK("halt_res", 1'b0, halt)
    $display("test judge_on done");
  endtask : t_judge_on

  task automatic t_rx_ack;
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0004);
    lnk(1'b0, 1'b1);
    `CHK("sda_ack0", 1'b0, seen)
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0005);
    lnk(1'b0, 1'b1);
    `CHK("sda_ack1", 1'b1, seen)
    `CHK("halt_rx", 1'b0, halt)
    $display("test rx_ack done");
  endtask : t_rx_ack

  task automatic t_stop;
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0008);
    wb(1'b1, IANC_OFS_MASK, 32'h0000_0002);
    i_ianc_link_model.modes(1'b0, 1'b1, 1'b0);
    ev(0);
    `CHK("stop_slave", 1'b0, sirq)
    i_ianc_link_model.modes(1'b1, 1'b1, 1'b0);
    ev(0);
    `CHK("stop_irq", 1'b1, sirq)
    `CHK("irq", 1'b1, irq)
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0000);
    `CHK("stop_off", 1'b0, sirq)
    wb(1'b1, IANC_OFS_STATUS, 32'h0000_0002);
    rd(IANC_OFS_STATUS, 32'h0000_0000, "status");
    $display("test stop done");
  endtask : t_stop

  task automatic t_arb_ovr;
    wb(1'b1, IANC_OFS_CTRL, 32'h0000_0010);
    wb(1'b1, IANC_OFS_MASK, 32'h0000_000C);
    ev(1);
    `CHK("arb_irq", 1'b1, nirq)
    `CHK("irq_arb", 1'b1, irq)
    wb(1'b1, IANC_OFS_STATUS, 32'h0000_0004);
    `CHK("arb_clr", 1'b0, nirq)
    ev(2);
    rd(IANC_OFS_STATUS, 32'h0000_0000, "ovr_i2c");
    i_ianc_link_model.modes(1'b0, 1'b0, 1'b1);
    ev(2);
    `CHK("ovr_irq", 1'b1, nirq)
    `CHK("irq_ovr", 1'b1, irq)
    wb(1'b1, IANC_OFS_STATUS, 32'h0000_0008);
    `CHK("ovr_clr", 1'b0, nirq)
    $display("test arb_ovr done");
  endtask : t_arb_ovr

  // ************************************************************
  // run control
  // ************************************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // watchdog far beyond the hundred or so cycles of the run
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    summarize();
  end

  // main sequence
  initial begin
    {rst_i, cyc, stb, we, adr, wdat} = {1'b1, 3'b000, 4'h0, 32'h0000_0000};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ctrl_rw();
    t_judge_off();
    t_judge_on();
    t_rx_ack();
    t_stop();
    t_arb_ovr();
    summarize();
  end
endmodule : ianc_top_tb_top

`undef CHK
`default_nettype wire
